/* File: dac_register_and_buffer_control_bench.sv */
// Self-checking bench of the converter register block.
// Assumes the event partner and the bound port checker.
`timescale 1ns/100ps
`include "dacrb_map.vh"

module dac_register_and_buffer_control_bench;
    reg          clock_in = 1'b0;
    reg          rst_n_in = 1'b0;
    reg  [7:0]   s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    reg  [31:0]  s_axi_wdata_in = 32'h0;
    reg  [3:0]   s_axi_wstrb_in = 4'hf;
    reg          s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    reg          s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, access_guard_lock_in = 1'b0;
    reg          supply_low_in = 1'b0, fire = 1'b0;
    reg  [3:0]   dly = 4'h0;
    wire         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    wire         s_axi_rvalid_out, converter_enabled_out, irq_request_out, start_event_in;
    wire         empty_event_out, conversion_start_out, pump_on_out;
    wire         internal_route_on_out, external_drive_on_out;
    wire [1:0]   s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0]  s_axi_rdata_out;
    wire [9:0]   dac_code_out;
    wire [7:0]   empties;
    int          err_count = 0, cmp_count = 0, cyc = 0;
    logic [33:0] rq [$];
    logic [1:0]  wq [$];
    logic [15:0] lfsr = 16'h0028;
    logic [7:0]  regs [9] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h30, 8'h40};

    always #25 clock_in = ~clock_in;

    dacrb_ctrl u_dut (.*);
    dacrb_partner u_partner (.clock_in(clock_in), .rst_n_in(rst_n_in), .fire_in(fire),
        .delay_in(dly), .empty_event_in(empty_event_out), .start_event_out(start_event_in),
        .empty_count_out(empties));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function logic [15:0] rnd(input logic [15:0] s);
        rnd = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    task chk(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `DACRB_RESP_OKAY);
        logic ta, tw, tb;
        begin
            wq.push_back(r);
            @(posedge clock_in);
            s_axi_awaddr_in <= a;
            s_axi_wdata_in <= d;
            s_axi_awvalid_in <= 1'b1;
            s_axi_wvalid_in <= 1'b1;
            s_axi_bready_in <= 1'b1;
            tb = 1'b0;
            while (!tb) begin
                @(negedge clock_in);
                ta = s_axi_awvalid_in && s_axi_awready_out;
                tw = s_axi_wvalid_in && s_axi_wready_out;
                tb = s_axi_bvalid_out && s_axi_bready_in;
                @(posedge clock_in);
                if (ta) s_axi_awvalid_in <= 1'b0;
                if (tw) s_axi_wvalid_in <= 1'b0;
                if (tb) s_axi_bready_in <= 1'b0;
            end
        end
    endtask

    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `DACRB_RESP_OKAY);
        logic ta, tr;
        begin
            rq.push_back({r, d});
            @(posedge clock_in);
            s_axi_araddr_in <= a;
            s_axi_arvalid_in <= 1'b1;
            s_axi_rready_in <= 1'b1;
            tr = 1'b0;
            while (!tr) begin
                @(negedge clock_in);
                ta = s_axi_arvalid_in && s_axi_arready_out;
                tr = s_axi_rvalid_out && s_axi_rready_in;
                @(posedge clock_in);
                if (ta) s_axi_arvalid_in <= 1'b0;
                if (tr) s_axi_rready_in <= 1'b0;
            end
        end
    endtask

    task start;
        @(posedge clock_in);
        fire <= 1'b1;
        dly <= lfsr[7:4];
        @(posedge clock_in);
        fire <= 1'b0;
        do @(negedge clock_in); while (!start_event_in);
        tick(4);
    endtask

    // Watcher of bus answers against the noted expectations
    always @(negedge clock_in) begin
        if (s_axi_rvalid_out && s_axi_rready_in) chk({s_axi_rresp_out, s_axi_rdata_out}, rq.pop_front());
        if (s_axi_bvalid_out && s_axi_bready_in) chk({32'h0, s_axi_bresp_out}, {32'h0, wq.pop_front()});
    end

    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        tick(2);
        rst_n_in <= 1'b1;
        foreach (regs[i]) rd(regs[i], 32'h0);
        rd(8'h0c, 32'h0, `DACRB_RESP_DECERR);
        $display("test reset values done");
        wr(8'h14, 32'h5);
        rd(8'h14, 32'h5);
        rd(8'h10, 32'h5);
        wr(8'h10, 32'h1);
        wr(8'h14, 32'h0);
        rd(8'h10, 32'h4);
        $display("test enables done");
        supply_low_in <= 1'b1;
        wr(8'h04, 32'h1f);
        wr(8'h40, 32'h1);
        rd(8'h04, 32'h1f);
        chk({30'h0, pump_on_out, internal_route_on_out, external_drive_on_out,
            converter_enabled_out}, 34'h7);
        wr(8'h04, 32'h0, `DACRB_RESP_SLVERR);
        wr(8'h40, 32'h0);
        wr(8'h04, 32'h04);
        wr(8'h40, 32'h1);
        chk({30'h0, pump_on_out, internal_route_on_out, external_drive_on_out,
            converter_enabled_out}, 34'h9);
        lfsr = rnd(lfsr);
        wr(8'h20, {16'h0, lfsr}); // Value written directly
        tick(2);
        chk({24'h0, dac_code_out}, {24'h0, lfsr[15:6]});
        rd(8'h20, {16'h0, lfsr});
        rd(8'h18, 32'h4);
        chk({33'h0, irq_request_out}, 34'h1);
        $display("test output control done");
        wr(8'h40, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h40, 32'h1);
        wr(8'h08, 32'h3);
        lfsr = rnd(lfsr);
        wr(8'h30, {16'h0, lfsr}); // Start events on, buffer written only
        rd(8'h30, {16'h0, lfsr});
        wr(8'h18, 32'h7);
        start();
        chk({24'h0, dac_code_out}, {24'h0, lfsr[9:0]});
        rd(8'h18, 32'h2);
        chk({26'h0, empties}, 34'h1);
        start();
        rd(8'h18, 32'h3);
        wr(8'h14, 32'h1);
        chk({33'h0, irq_request_out}, 34'h1);
        wr(8'h10, 32'h5);
        chk({33'h0, irq_request_out}, 34'h0);
        wr(8'h18, 32'h0);
        rd(8'h18, 32'h3);
        wr(8'h18, 32'h1);
        rd(8'h18, 32'h2);
        fork
            wr(8'h30, {16'h0, lfsr});
            @(posedge clock_in) rd(8'h1c, 32'h80);
        join
        rd(8'h18, 32'h4);
        wr(8'h08, 32'h1);
        wr(8'h18, 32'h7);
        start();
        rd(8'h18, 32'h2);
        chk({26'h0, empties}, 34'h1);
        $display("test buffer done");
        access_guard_lock_in <= 1'b1;
        wr(8'h08, 32'h3, `DACRB_RESP_SLVERR);
        wr(8'h30, {16'h0, lfsr}, `DACRB_RESP_SLVERR);
        access_guard_lock_in <= 1'b0;
        wr(8'h40, 32'h0);
        wr(8'h04, 32'h10);
        wr(8'h40, 32'h1);
        access_guard_lock_in <= 1'b1;
        wr(8'h30, {16'h0, lfsr});
        access_guard_lock_in <= 1'b0;
        wr(8'h08, 32'h0);
        wr(8'h18, 32'h7);
        start();
        rd(8'h18, 32'h0);
        access_guard_lock_in <= 1'b1;
        wr(8'h20, 32'h1, `DACRB_RESP_SLVERR);
        access_guard_lock_in <= 1'b0;
        $display("test guard done");
        wr(8'h40, 32'h2);
        rd(8'h04, 32'h0);
        rd(8'h40, 32'h0);
        $display("test software reset done");
        give_verdict();
    end
endmodule

/* File: dacrb_ctrl.v */
// Register and two-stage data buffer control of a 10-bit converter.
// Assumes an AXI4-Lite master on the register bus, one-cycle start event
// pulses and a level write-lock from the access guard, all on clock_in.
//
// Overview of operation
// - Bypass bit exempts buffer from access guard
// - Pump automatic at 0, forced off at 1
// - Code in bits 9:0, or 15:6 when aligned high
// - Internal route bit feeds comparator path
// - External drive bit enables output buffer
// - Empty event emitted when enabled
// - Enabled start event loads value from buffer, starts conversion
// - Enable-clear write-one clears, both read alike
// - Enable-set write-one sets enable bits
// - Empty flag sets on buffer transfer
// - Empty flag cleared by one or buffer write
// - Underrun on start with empty buffer
// - Busy status spans register synchronization
// - Value register synchronized, guarded, resets zero
// - Buffer register holds next value, synchronized
// - Output control writable only while disabled
`timescale 1ns/100ps
`include "dacrb_map.vh"

module dacrb_ctrl (
    // Clock and reset
    input  wire        clock_in,
    input  wire        rst_n_in,
    // AXI4-Lite write address and data
    input  wire [7:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output wire        s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output wire        s_axi_wready_out,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output wire        s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    // Events and access guard
    input  wire        start_event_in,
    input  wire        access_guard_lock_in,
    output reg         empty_event_out,
    output reg         conversion_start_out,
    // Analog side
    input  wire        supply_low_in,
    output reg  [9:0]  dac_code_out,
    output wire        converter_enabled_out,
    output wire        pump_on_out,
    output wire        internal_route_on_out,
    output wire        external_drive_on_out,
    output wire        irq_request_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg        aw_full_q;
    reg [7:0]  awaddr_q;
    reg        w_full_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    reg        ar_full_q;
    reg [7:0]  araddr_q;
    reg        rd_sync_q;
    reg [7:0]  outctl_q;
    reg [7:0]  evctl_q;
    reg [7:0]  ien_q;
    reg [7:0]  iflag_q;
    reg [15:0] value_q;
    reg [15:0] buffer_q;
    reg        buf_full_q;
    reg        enable_q;
    reg [1:0]  sync_cnt_q;

    reg [7:0]  outctl_d;
    reg [7:0]  evctl_d;
    reg [7:0]  ien_d;
    reg [7:0]  iflag_d;
    reg [15:0] value_d;
    reg [15:0] buffer_d;
    reg        buf_full_d;
    reg        enable_d;
    reg [1:0]  sync_cnt_d;
    reg        swreset;
    reg [7:0]  flag_set;
    reg [7:0]  flag_clr;
    reg [1:0]  wr_resp;
    reg [31:0] rd_word;
    reg [1:0]  rd_resp;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte-lane merge of a written word into a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
            merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    // Picks the 10-bit code out of a 16-bit word by alignment
    function [9:0] code_of;
        input [15:0] word;
        input        high;
        begin
            code_of = high ? word[15:6] : word[9:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire [5:0] wr_idx    = awaddr_q[7:2];
    wire [5:0] rd_idx    = araddr_q[7:2];
    wire       sync_busy = (sync_cnt_q != 2'h0);
    wire       sync_last = (sync_cnt_q == 2'h1);
    wire       wr_synced = (wr_idx == `DACRB_IDX_VALUE) || (wr_idx == `DACRB_IDX_BUFFER);
    wire       rd_is_val = (rd_idx == `DACRB_IDX_VALUE);

    // Synchronized writes wait until the previous synchronization ends
    wire wr_go = aw_full_q & w_full_q & ~s_axi_bvalid_out & ~(wr_synced & sync_busy);
    // Value reads run their own synchronization before the answer
    wire rd_start = ar_full_q & rd_is_val & ~rd_sync_q & ~sync_busy
                    & ~(wr_go & wr_synced) & ~s_axi_rvalid_out;
    wire rd_go = ar_full_q & ~s_axi_rvalid_out & (~rd_is_val | (rd_sync_q & ~sync_busy));

    assign s_axi_awready_out = ~aw_full_q;
    assign s_axi_wready_out  = ~w_full_q;
    assign s_axi_arready_out = ~ar_full_q;

    wire wr_one   = wr_go & wstrb_q[0];
    wire guard_on = access_guard_lock_in;
    wire buf_open = ~guard_on | outctl_q[`DACRB_OC_BUF_BYPASS];
    wire start_ok = start_event_in & evctl_q[`DACRB_EV_START_IN];

    // ------------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------------
    always @* begin
        outctl_d   = outctl_q;
        evctl_d    = evctl_q;
        ien_d      = ien_q;
        value_d    = value_q;
        buffer_d   = buffer_q;
        buf_full_d = buf_full_q;
        enable_d   = enable_q;
        sync_cnt_d = sync_busy ? sync_cnt_q - 2'h1 : 2'h0;
        swreset    = 1'b0;
        flag_set   = 8'h00;
        flag_clr   = 8'h00;
        wr_resp    = `DACRB_RESP_OKAY;

        if (wr_go) begin
            case (wr_idx)
                `DACRB_IDX_OUTCTL: begin
                    if (guard_on || enable_q)
                        wr_resp = `DACRB_RESP_SLVERR;
                    else if (wr_one)
                        outctl_d = wdata_q[7:0] & `DACRB_OC_MASK;
                end
                `DACRB_IDX_EVCTL: begin
                    if (guard_on)
                        wr_resp = `DACRB_RESP_SLVERR;
                    else if (wr_one)
                        evctl_d = wdata_q[7:0] & `DACRB_EV_MASK;
                end
                `DACRB_IDX_IENCLR: begin
                    if (guard_on)
                        wr_resp = `DACRB_RESP_SLVERR;
                    else if (wr_one)
                        ien_d = ien_q & ~(wdata_q[7:0] & `DACRB_FL_MASK);
                end
                `DACRB_IDX_IENSET: begin
                    if (guard_on)
                        wr_resp = `DACRB_RESP_SLVERR;
                    else if (wr_one)
                        ien_d = ien_q | (wdata_q[7:0] & `DACRB_FL_MASK);
                end
                `DACRB_IDX_IFLAG: begin
                    if (guard_on)
                        wr_resp = `DACRB_RESP_SLVERR;
                    else if (wr_one)
                        flag_clr = wdata_q[7:0] & `DACRB_FL_MASK;
                end
                `DACRB_IDX_STATUS: begin
                    wr_resp = `DACRB_RESP_OKAY;
                end
                `DACRB_IDX_VALUE: begin
                    if (guard_on)
                        wr_resp = `DACRB_RESP_SLVERR;
                    else if (wstrb_q[1:0] != 2'h0) begin
                        value_d    = merge16(value_q, wdata_q, wstrb_q);
                        sync_cnt_d = `DACRB_SYNC_CYCLES;
                    end
                end
                `DACRB_IDX_BUFFER: begin
                    if (!buf_open)
                        wr_resp = `DACRB_RESP_SLVERR;
                    else if (wstrb_q[1:0] != 2'h0) begin
                        buffer_d   = merge16(buffer_q, wdata_q, wstrb_q);
                        buf_full_d = 1'b1;
                        sync_cnt_d = `DACRB_SYNC_CYCLES;
                        flag_clr   = flag_clr | (8'h01 << `DACRB_FL_EMPTY);
                    end
                end
                `DACRB_IDX_RUNCTL: begin
                    if (guard_on)
                        wr_resp = `DACRB_RESP_SLVERR;
                    else if (wr_one && wdata_q[`DACRB_RUN_SWRESET])
                        swreset = 1'b1;
                    else if (wr_one)
                        enable_d = wdata_q[`DACRB_RUN_ENABLE];
                end
                default: wr_resp = `DACRB_RESP_DECERR;
            endcase
        end

        if (rd_start)
            sync_cnt_d = `DACRB_SYNC_CYCLES;

        if (sync_last)
            flag_set = flag_set | (8'h01 << `DACRB_FL_SYNC_DONE);

        // Start event: transfer when the buffer holds data, else underrun
        if (start_ok) begin
            if (buf_full_q) begin
                value_d    = buffer_q;
                buf_full_d = 1'b0;
                flag_set   = flag_set | (8'h01 << `DACRB_FL_EMPTY);
            end else begin
                flag_set   = flag_set | (8'h01 << `DACRB_FL_UNDERRUN);
            end
        end

        // A flag raised in the same cycle as its clear stays raised
        iflag_d = (iflag_q & ~flag_clr) | flag_set;
    end

    // ------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------
    always @* begin
        rd_word = 32'h0000_0000;
        rd_resp = `DACRB_RESP_OKAY;
        case (rd_idx)
            `DACRB_IDX_OUTCTL: rd_word[7:0]  = outctl_q;
            `DACRB_IDX_EVCTL:  rd_word[7:0]  = evctl_q;
            `DACRB_IDX_IENCLR: rd_word[7:0]  = ien_q;
            `DACRB_IDX_IENSET: rd_word[7:0]  = ien_q;
            `DACRB_IDX_IFLAG:  rd_word[7:0]  = iflag_q;
            `DACRB_IDX_STATUS: rd_word[`DACRB_ST_SYNC_BUSY] = sync_busy;
            `DACRB_IDX_VALUE:  rd_word[15:0] = value_q;
            `DACRB_IDX_BUFFER: rd_word[15:0] = buffer_q;
            `DACRB_IDX_RUNCTL: rd_word[`DACRB_RUN_ENABLE] = enable_q;
            default:           rd_resp = `DACRB_RESP_DECERR;
        endcase
    end

    // ------------------------------------------------------------------
    // Bus handshake registers
    // ------------------------------------------------------------------
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_full_q        <= 1'b0;
            awaddr_q         <= 8'h00;
            w_full_q         <= 1'b0;
            wdata_q          <= 32'h0000_0000;
            wstrb_q          <= 4'h0;
            ar_full_q        <= 1'b0;
            araddr_q         <= 8'h00;
            rd_sync_q        <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= 2'h0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rresp_out  <= 2'h0;
            s_axi_rdata_out  <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid_in && !aw_full_q) begin
                aw_full_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr_in;
            end else if (wr_go) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid_in && !w_full_q) begin
                w_full_q <= 1'b1;
                wdata_q  <= s_axi_wdata_in;
                wstrb_q  <= s_axi_wstrb_in;
            end else if (wr_go) begin
                w_full_q <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= wr_resp;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end

            if (s_axi_arvalid_in && !ar_full_q) begin
                ar_full_q <= 1'b1;
                araddr_q  <= s_axi_araddr_in;
            end else if (rd_go) begin
                ar_full_q <= 1'b0;
            end
            if (rd_start)
                rd_sync_q <= 1'b1;
            else if (rd_go)
                rd_sync_q <= 1'b0;
            if (rd_go) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= rd_word;
                s_axi_rresp_out  <= rd_resp;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers, cleared by reset or software reset
    // ------------------------------------------------------------------
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            outctl_q   <= `DACRB_RST_REG8;
            evctl_q    <= `DACRB_RST_REG8;
            ien_q      <= `DACRB_RST_REG8;
            iflag_q    <= `DACRB_RST_REG8;
            value_q    <= `DACRB_RST_REG16;
            buffer_q   <= `DACRB_RST_REG16;
            buf_full_q <= 1'b0;
            enable_q   <= 1'b0;
            sync_cnt_q <= 2'h0;
        end else if (swreset) begin
            outctl_q   <= `DACRB_RST_REG8;
            evctl_q    <= `DACRB_RST_REG8;
            ien_q      <= `DACRB_RST_REG8;
            iflag_q    <= `DACRB_RST_REG8;
            value_q    <= `DACRB_RST_REG16;
            buffer_q   <= `DACRB_RST_REG16;
            buf_full_q <= 1'b0;
            enable_q   <= 1'b0;
            sync_cnt_q <= 2'h0;
        end else begin
            outctl_q   <= outctl_d;
            evctl_q    <= evctl_d;
            ien_q      <= ien_d;
            iflag_q    <= iflag_d;
            value_q    <= value_d;
            buffer_q   <= buffer_d;
            buf_full_q <= buf_full_d;
            enable_q   <= enable_d;
            sync_cnt_q <= sync_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Converter-side outputs
    // ------------------------------------------------------------------
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dac_code_out         <= 10'h000;
            empty_event_out      <= 1'b0;
            conversion_start_out <= 1'b0;
        end else begin
            dac_code_out <= code_of(value_q, outctl_q[`DACRB_OC_HIGH_ALIGN]);
            // One pulse per transfer that leaves the buffer empty
            empty_event_out <= start_ok & buf_full_q & ~swreset
                               & evctl_q[`DACRB_EV_EMPTY_OUT];
            conversion_start_out <= start_ok & ~swreset;
        end
    end

    assign converter_enabled_out = enable_q;
    assign pump_on_out = enable_q & supply_low_in
                         & ~outctl_q[`DACRB_OC_PUMP_DIS];
    assign internal_route_on_out = enable_q & outctl_q[`DACRB_OC_INT_ROUTE];
    assign external_drive_on_out = enable_q & outctl_q[`DACRB_OC_EXT_DRIVE];
    assign irq_request_out = |(iflag_q & ien_q);

endmodule

/* File: dacrb_map.vh */
// Register map, field positions, reset values and timing counts of the
// converter register and buffer control block.
// Assumes a 32-bit register bus with one aligned word per register index.
`ifndef DACRB_MAP_VH
`define DACRB_MAP_VH

// ----------------------------------------------------------------------
// Bus widths and responses
// ----------------------------------------------------------------------
`define DACRB_ADDR_W        8
`define DACRB_RESP_OKAY     2'h0
`define DACRB_RESP_SLVERR   2'h2
`define DACRB_RESP_DECERR   2'h3

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DACRB_IDX_OUTCTL    6'h01
`define DACRB_IDX_EVCTL     6'h02
`define DACRB_IDX_IENCLR    6'h04
`define DACRB_IDX_IENSET    6'h05
`define DACRB_IDX_IFLAG     6'h06
`define DACRB_IDX_STATUS    6'h07
`define DACRB_IDX_VALUE     6'h08
`define DACRB_IDX_BUFFER    6'h0c
`define DACRB_IDX_RUNCTL    6'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DACRB_OC_EXT_DRIVE  0
`define DACRB_OC_INT_ROUTE  1
`define DACRB_OC_HIGH_ALIGN 2
`define DACRB_OC_PUMP_DIS   3
`define DACRB_OC_BUF_BYPASS 4
`define DACRB_OC_MASK       8'h1f
`define DACRB_EV_START_IN   0
`define DACRB_EV_EMPTY_OUT  1
`define DACRB_EV_MASK       8'h03
`define DACRB_FL_UNDERRUN   0
`define DACRB_FL_EMPTY      1
`define DACRB_FL_SYNC_DONE  2
`define DACRB_FL_MASK       8'h07
`define DACRB_ST_SYNC_BUSY  7
`define DACRB_RUN_ENABLE    0
`define DACRB_RUN_SWRESET   1

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define DACRB_RST_REG8      8'h00
`define DACRB_RST_REG16     16'h0000
`define DACRB_SYNC_CYCLES   2'h3

`endif

/* File: dacrb_monitor.sv */
// Port checker of the converter register and buffer control block.
// Assumes binding into dacrb_ctrl; one clock, reset active low.
`timescale 1ns/100ps
`include "dacrb_map.vh"

module dacrb_monitor (
    // Clock, reset and bus
    input wire        clock_in,
    input wire        rst_n_in,
    input wire [7:0]  s_axi_araddr_in,
    input wire        s_axi_arvalid_in,
    input wire        s_axi_arready_out,
    input wire [31:0] s_axi_rdata_out,
    input wire [1:0]  s_axi_rresp_out,
    input wire        s_axi_rvalid_out,
    input wire        s_axi_bvalid_out,
    // Events and analog side
    input wire        start_event_in,
    input wire        supply_low_in,
    input wire        empty_event_out,
    input wire        conversion_start_out,
    input wire [9:0]  dac_code_out,
    input wire        converter_enabled_out,
    input wire        pump_on_out,
    input wire        internal_route_on_out,
    input wire        external_drive_on_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    a_empty_one_cycle: assert property (empty_event_out |=> !empty_event_out)
        else $error("empty event longer than one cycle");
    a_empty_with_start: assert property (empty_event_out |-> conversion_start_out)
        else $error("empty event without a transfer");
    a_start_has_cause: assert property (conversion_start_out |-> $past(start_event_in))
        else $error("conversion start without event");
    a_pump_gated: assert property (pump_on_out |-> converter_enabled_out && supply_low_in)
        else $error("pump on without cause");
    a_route_gated: assert property (internal_route_on_out |-> converter_enabled_out)
        else $error("internal route while disabled");
    a_drive_gated: assert property (external_drive_on_out |-> converter_enabled_out)
        else $error("output drive while disabled");
    a_code_has_cause: assert property ($changed(dac_code_out) |-> $past(conversion_start_out)
        || $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2))
        else $error("code changed without cause");
    a_value_read_sync: assert property (s_axi_arvalid_in && s_axi_arready_out
        && s_axi_araddr_in[7:2] == `DACRB_IDX_VALUE |=> !s_axi_rvalid_out [*3])
        else $error("value read answered before sync");
    a_unmapped_zero: assert property (s_axi_rvalid_out
        && s_axi_rresp_out == `DACRB_RESP_DECERR |-> s_axi_rdata_out == 32'h0)
        else $error("unmapped read data not zero");
endmodule

bind dacrb_ctrl dacrb_monitor u_mon (.*);

/* File: dacrb_partner.sv */
// Event routing partner: delayed start pulses, empty events counted.
// Assumes the clock and reset of the converter block.
`timescale 1ns/100ps

module dacrb_partner (
    // Clock, reset and requests
    input  wire       clock_in,
    input  wire       rst_n_in,
    input  wire       fire_in,
    input  wire [3:0] delay_in,
    // Event lines
    input  wire       empty_event_in,
    output reg        start_event_out,
    output reg  [7:0] empty_count_out
);
    reg       armed_q;
    reg [3:0] wait_q;

    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            armed_q         <= 1'b0;
            wait_q          <= 4'h0;
            start_event_out <= 1'b0;
            empty_count_out <= 8'h00;
        end else begin
            start_event_out <= armed_q && wait_q == 4'h0;
            if (fire_in && !armed_q) begin
                armed_q <= 1'b1;
                wait_q  <= delay_in;
            end else if (armed_q && wait_q == 4'h0) begin
                armed_q <= 1'b0;
            end else if (armed_q) begin
                wait_q <= wait_q - 4'h1;
            end
            if (empty_event_in) begin
                empty_count_out <= empty_count_out + 8'h01;
            end
        end
    end
endmodule
